/* core/cfl_pkg.sv */
`default_nettype none
package cfl_pkg;

	////////////////////////////////////////////////////////////////////
	// buffer geometry, all in 16-bit words
	localparam int          NUM_CHIPS   = 4;
	localparam int          CNT_W       = 19;
	localparam logic [18:0] BUF_WORDS   = 19'h40000;
	// 64K - 128: almost empty level, also almost full in the V3 variant
	localparam logic [18:0] AE_LEVEL    = 19'h0FF80;
	// 128K - 256: almost full level of the V2 variant
	localparam logic [18:0] AF_LEVEL_V2 = 19'h1FF00;
	// half full has no meaning for the cascaded buffer
	localparam logic        HFULL_FIXED = 1'b0;

	////////////////////////////////////////////////////////////////////
	// timing
	localparam int          CLK_PERIOD_NS = 50;
	localparam int          DWELL_NS      = 400;
	localparam int          DWELL_CYC     =
		(DWELL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// the idle cycle and the pulse cycle are part of the dwell
	localparam logic [3:0]  DWELL_LOAD    = 4'(DWELL_CYC - 2);

	////////////////////////////////////////////////////////////////////
	// register offsets (byte addresses)
	localparam logic [7:0]  REG_CTRL     = 8'h00;
	localparam logic [7:0]  REG_WORDS    = 8'h04;
	localparam logic [7:0]  REG_FLAGS    = 8'h08;
	localparam logic [7:0]  REG_FILL     = 8'h0C;
	localparam logic [7:0]  REG_IRQ_STAT = 8'h10;
	localparam logic [7:0]  REG_IRQ_MASK = 8'h14;

	// field positions
	localparam int          CTRL_COPY_DIS = 0;
	localparam int          IRQ_AFULL     = 0;
	localparam int          IRQ_FULL      = 1;
	localparam int          IRQ_LOST      = 2;
	localparam int          IRQ_W         = 3;

	// reset values
	localparam logic        COPY_DIS_RST  = 1'b0;
	localparam logic [5:0]  WORDS_RST     = 6'h20;
	localparam logic [2:0]  IRQ_MASK_RST  = 3'h0;

	////////////////////////////////////////////////////////////////////
	// types
	typedef struct packed {
		logic full;
		logic afull;
		logic hfull;
		logic aempty;
		logic empty;
	} cfl_flags_t;

	typedef enum logic [1:0] {
		CFL_IDLE,
		CFL_COPY,
		CFL_DWELL
	} cfl_state_t;

endpackage
`default_nettype wire

/* core/cfl_ring.sv */
`timescale 1ns/10ps
`default_nettype none
module cfl_ring
	import cfl_pkg::*;
#(
	parameter bit FOUR_CHIPS = 1'b1,
	parameter bit VARIANT_V3 = 1'b0
) (
	// clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// requests
	input  wire logic         wr_go,
	input  wire logic         rd_go,
	// synchronised flags of a lone chip
	input  wire cfl_flags_t   single_flags,
	// chip strobes and status
	output logic [3:0]        chip_wr_en,
	output logic [3:0]        chip_rd_en,
	output cfl_flags_t        flags,
	output logic [CNT_W-1:0]  fill
);

	////////////////////////////////////////////////////////////////////
	// ring order helpers
	function automatic logic [3:0] onehot(input logic [1:0] p);
		onehot = 4'h1 << p;
	endfunction

	function automatic logic [1:0] step(input logic [1:0] p);
		step = FOUR_CHIPS ? 2'(p + 2'h1) : 2'h0;
	endfunction

	// flags from the combined fill of all chips
	function automatic cfl_flags_t combine(input logic [CNT_W-1:0] f);
		// empty only with all chips drained
		combine.empty  = (f == '0);
		combine.aempty = (f >= AE_LEVEL);
		combine.hfull  = HFULL_FIXED;
		combine.afull  = VARIANT_V3 ? (f >= AE_LEVEL) : (f >= AF_LEVEL_V2);
		// full only at whole ring capacity
		combine.full   = (f == BUF_WORDS);
	endfunction

	logic [1:0]        wptr;
	logic [1:0]        rptr;
	logic              wr_ok;
	logic              rd_ok;
	logic [CNT_W-1:0]  next_fill;

	// full and empty refuse the strobe, so the count never wraps
	assign wr_ok     = wr_go & ~flags.full;
	assign rd_ok     = rd_go & ~flags.empty;
	assign next_fill = CNT_W'(fill + CNT_W'(wr_ok) - CNT_W'(rd_ok));

	////////////////////////////////////////////////////////////////////
	// ring order strobes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wptr       <= 2'h0;
			rptr       <= 2'h0;
			chip_wr_en <= 4'h0;
			chip_rd_en <= 4'h0;
			fill       <= '0;
		end else begin
			wptr       <= wr_ok ? step(wptr) : wptr;
			rptr       <= rd_ok ? step(rptr) : rptr;
			chip_wr_en <= wr_ok ? onehot(wptr) : 4'h0;
			chip_rd_en <= rd_ok ? onehot(rptr) : 4'h0;
			fill       <= next_fill;
		end
	end

	// lone chip reports its own flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags <= '{full: 1'b0, afull: 1'b0, hfull: HFULL_FIXED,
				aempty: 1'b0, empty: 1'b1};
		end else begin
			flags <= FOUR_CHIPS ? combine(next_fill) : single_flags;
		end
	end

endmodule
`default_nettype wire

/* core/cfl_top.sv */
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - one chip reports own flags directly
// - four chips written and read in ring
// - almost empty threshold at 64K-128 words
// - V2 almost full at 128K-256 words
// - V3 almost full uses almost empty level
// - almost full, full and lost bin may raise interrupt
// - room for 128K+256 while not almost full
// - no copy pulses while buffer full
// - copy disable copies nothing, pulses continue
// - minimum dwell 400 ns between copy cycles
module cfl_top
	import cfl_pkg::*;
#(
	parameter bit FOUR_CHIPS = 1'b1,
	parameter bit VARIANT_V3 = 1'b0,
	parameter int WORDS_W    = 6
) (
	// clock and reset
	input  wire logic          pclk,
	input  wire logic          presetn,
	// apb slave
	input  wire logic [7:0]    paddr,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [31:0]   pwdata,
	output logic [31:0]        prdata,
	output logic               pready,
	output logic               pslverr,
	// bin timing and reading master
	input  wire logic          next_bin_pulse,
	input  wire logic          rd_req,
	// flag pins of a lone chip
	input  wire cfl_flags_t    chip_flags_pin,
	// chip strobes
	output logic [3:0]         chip_wr_en,
	output logic [3:0]         chip_rd_en,
	output logic [WORDS_W-1:0] copy_chan,
	// status
	output logic               copy_pulse_out,
	output cfl_flags_t         fifo_flags,
	output logic               irq
);

	////////////////////////////////////////////////////////////////////
	// declarations
	cfl_state_t          state;
	cfl_state_t          next_state;
	logic [WORDS_W-1:0]  idx;
	logic [WORDS_W-1:0]  next_idx;
	logic [3:0]          dwell;
	logic [3:0]          next_dwell;
	logic                pending;
	logic                next_pending;
	logic                next_pulse;
	logic                wr_go;
	logic                consume;
	logic                lost;
	logic                last_word;
	logic                no_copy;
	logic                full;

	logic                copy_dis;
	logic [WORDS_W-1:0]  words;
	logic [IRQ_W-1:0]    irq_stat;
	logic [IRQ_W-1:0]    irq_mask;
	logic [IRQ_W-1:0]    next_irq_stat;
	logic [IRQ_W-1:0]    irq_ev;
	logic [IRQ_W-1:0]    w1c;
	logic                afull_d;
	logic                full_d;

	cfl_flags_t          flags_meta;
	cfl_flags_t          flags_sync;
	logic [CNT_W-1:0]    fill;

	logic                setup;
	logic                access;
	logic                wr_acc;
	logic                hit_ctrl;
	logic                hit_words;
	logic                hit_flags;
	logic                hit_fill;
	logic                hit_stat;
	logic                hit_mask;
	logic                mapped;
	logic [31:0]         rd_mux;

	////////////////////////////////////////////////////////////////////
	// flag pins of a lone chip cross from the board, two stages first
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_meta <= '0;
			flags_sync <= '0;
		end else begin
			flags_meta <= chip_flags_pin;
			flags_sync <= flags_meta;
		end
	end

	////////////////////////////////////////////////////////////////////
	// ring buffer bookkeeping and flag combining
	// variant chosen at build time
	cfl_ring #(
		.FOUR_CHIPS   (FOUR_CHIPS),
		.VARIANT_V3   (VARIANT_V3)
	) u_ring (
		.pclk         (pclk),
		.presetn      (presetn),
		.wr_go        (wr_go),
		.rd_go        (rd_req),
		.single_flags (flags_sync),
		.chip_wr_en   (chip_wr_en),
		.chip_rd_en   (chip_rd_en),
		.flags        (fifo_flags),
		.fill         (fill)
	);

	assign full = fifo_flags.full;

	////////////////////////////////////////////////////////////////////
	// copy sequencer: one pulse per served bin, then words, then dwell
	// copy disable skips the words
	assign no_copy   = copy_dis | (words == '0);
	assign last_word = (idx == WORDS_W'(words - 1'b1));
	// full holds the bin back, no pulse
	assign consume   = (state == CFL_IDLE) & pending & ~full;
	// a second bin while one waits is lost, not queued
	assign lost      = next_bin_pulse & pending & ~consume;
	assign next_pending = next_bin_pulse | (pending & ~consume);

	always_comb begin
		next_state = state;
		next_idx   = idx;
		next_dwell = dwell;
		next_pulse = 1'b0;
		wr_go      = 1'b0;
		case (state)
			CFL_IDLE: begin
				if (consume) begin
					next_pulse = 1'b1;
					next_idx   = '0;
					if (no_copy) begin
						next_state = CFL_DWELL;
						next_dwell = DWELL_LOAD;
					end else begin
						next_state = CFL_COPY;
					end
				end
			end
			CFL_COPY: begin
				// a full buffer stalls the copy mid bin
				if (!full) begin
					wr_go    = 1'b1;
					next_idx = WORDS_W'(idx + 1'b1);
					if (last_word) begin
						next_state = CFL_DWELL;
						next_dwell = DWELL_LOAD;
					end
				end
			end
			CFL_DWELL: begin
				if (dwell == 4'h0) begin
					next_state = CFL_IDLE;
				end else begin
					next_dwell = dwell - 4'h1;
				end
			end
			default: begin
				next_state = CFL_IDLE;
			end
		endcase
	end

	// sequencer state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state          <= CFL_IDLE;
			idx            <= '0;
			dwell          <= 4'h0;
			pending        <= 1'b0;
			copy_pulse_out <= 1'b0;
		end else begin
			state          <= next_state;
			idx            <= next_idx;
			dwell          <= next_dwell;
			pending        <= next_pending;
			copy_pulse_out <= next_pulse;
		end
	end

	// channel index lines up with the chip strobe it belongs to
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			copy_chan <= '0;
		end else if (wr_go) begin
			copy_chan <= idx;
		end
	end

	////////////////////////////////////////////////////////////////////
	// apb decode
	assign setup     = psel & ~penable;
	assign access    = psel & penable & pready;
	assign wr_acc    = access & pwrite;
	assign hit_ctrl  = (paddr == REG_CTRL);
	assign hit_words = (paddr == REG_WORDS);
	assign hit_flags = (paddr == REG_FLAGS);
	assign hit_fill  = (paddr == REG_FILL);
	assign hit_stat  = (paddr == REG_IRQ_STAT);
	assign hit_mask  = (paddr == REG_IRQ_MASK);
	assign mapped    = hit_ctrl | hit_words | hit_flags | hit_fill
		| hit_stat | hit_mask;

	// read mux, unused bits read zero
	assign rd_mux =
		hit_ctrl  ? {31'h0, copy_dis} :
		hit_words ? {{(32-WORDS_W){1'b0}}, words} :
		hit_flags ? {27'h0, fifo_flags} :
		hit_fill  ? {13'h0, fill} :
		hit_stat  ? {29'h0, irq_stat} :
		hit_mask  ? {29'h0, irq_mask} :
		32'h0;

	// no wait state: answer in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~mapped;
			prdata  <= (setup & ~pwrite) ? rd_mux : 32'h0;
		end
	end

	// software settings
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			copy_dis <= COPY_DIS_RST;
			words    <= WORDS_W'(WORDS_RST);
			irq_mask <= IRQ_MASK_RST;
		end else if (wr_acc) begin
			if (hit_ctrl) begin
				copy_dis <= pwdata[CTRL_COPY_DIS];
			end else if (hit_words) begin
				words <= pwdata[WORDS_W-1:0];
			end else if (hit_mask) begin
				irq_mask <= pwdata[IRQ_W-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// interrupts: sticky, write one to clear, a new event wins
	// almost empty is no interrupt source
	assign irq_ev[IRQ_AFULL] = fifo_flags.afull & ~afull_d;
	assign irq_ev[IRQ_FULL]  = fifo_flags.full & ~full_d;
	assign irq_ev[IRQ_LOST]  = lost;
	assign w1c = (wr_acc & hit_stat) ? pwdata[IRQ_W-1:0] : '0;
	assign next_irq_stat = (irq_stat & ~w1c) | irq_ev;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			afull_d  <= 1'b0;
			full_d   <= 1'b0;
			irq_stat <= '0;
			irq      <= 1'b0;
		end else begin
			afull_d  <= fifo_flags.afull;
			full_d   <= fifo_flags.full;
			irq_stat <= next_irq_stat;
			irq      <= |(next_irq_stat & irq_mask);
		end
	end

endmodule
`default_nettype wire

/* verification/cfl_props.sv */
`timescale 1ns/10ps
`default_nettype none
module cfl_props
	import cfl_pkg::*;
(
	// clock and reset
	input wire logic       pclk,
	input wire logic       presetn,
	// apb and read request
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	input wire logic       rd_req,
	// buffer side
	input wire logic [3:0] chip_wr_en,
	input wire logic [3:0] chip_rd_en,
	input wire logic       copy_pulse_out,
	input wire cfl_flags_t fifo_flags
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////
	// shadow fill, strobes of this cycle included
	logic [18:0] cnt;
	logic [18:0] lvl;
	logic [3:0]  wpos;
	logic [3:0]  rpos;
	assign lvl = cnt + 19'(|chip_wr_en) - 19'(|chip_rd_en);
	// expected ring positions follow each strobe
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt  <= 19'h0;
			wpos <= 4'h1;
			rpos <= 4'h1;
		end else begin
			cnt <= lvl;
			if (|chip_wr_en)
				wpos <= {wpos[2:0], wpos[3]};
			if (|chip_rd_en)
				rpos <= {rpos[2:0], rpos[3]};
		end
	end
	////////////////////////////////////////
	AST_EMPTY: assert property (fifo_flags.empty == (lvl == 19'h0))
		else $error("empty flag wrong");
	AST_FULL: assert property (fifo_flags.full == (lvl == BUF_WORDS))
		else $error("full flag wrong");
	AST_AEMPTY: assert property (fifo_flags.aempty == (lvl >= AE_LEVEL))
		else $error("almost empty wrong");
	// default build is the V2 variant
	AST_AFULL: assert property (fifo_flags.afull == (lvl >= AF_LEVEL_V2))
		else $error("almost full wrong");
	AST_HFULL: assert property (fifo_flags.hfull == HFULL_FIXED)
		else $error("half full not fixed");
	AST_NOPULSE: assert property (copy_pulse_out |->
		!$past(fifo_flags.full)) else $error("copy pulse while full");
	AST_DWELL: assert property (copy_pulse_out |=>
		!copy_pulse_out [*7]) else $error("copy pulses too close");
	AST_WRING: assert property (|chip_wr_en |-> chip_wr_en == wpos)
		else $error("write ring order");
	AST_RRING: assert property (|chip_rd_en |-> chip_rd_en == rpos)
		else $error("read ring order");
	AST_RDOK: assert property (|chip_rd_en |->
		$past(rd_req && !fifo_flags.empty)) else $error("bad read strobe");
	AST_APB: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("pready not one pulse");
	C_PULSE: cover property (copy_pulse_out);
	C_READ: cover property (|chip_rd_en && |chip_wr_en);
	C_DRAIN: cover property (|chip_rd_en ##1 fifo_flags.empty);
endmodule
bind cfl_top cfl_props u_cfl_props (.pclk, .presetn, .psel, .penable,
	.pready, .rd_req, .chip_wr_en, .chip_rd_en, .copy_pulse_out,
	.fifo_flags);
`default_nettype wire

/* verification/cfl_reader.sv */
`timescale 1ns/10ps
`default_nettype none
module cfl_reader
	import cfl_pkg::*;
(
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// bench control
	input  wire logic       en,
	input  wire logic       slow,
	// buffer side
	input  wire cfl_flags_t fifo_flags,
	output logic            rd_req
);
	logic ph;
	// block read master, slow mode every other cycle
	// reads while data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_req <= 1'b0;
			ph     <= 1'b0;
		end else begin
			ph     <= ~ph;
			rd_req <= en && !fifo_flags.empty && (!slow || ph);
		end
	end
endmodule
`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top
	import cfl_pkg::*;
;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        nb = 1'b0;
	logic        rd_req;
	logic        en = 1'b0;
	logic        slow = 1'b1;
	logic [3:0]  wr_en;
	logic [3:0]  rd_en;
	logic [5:0]  chan;
	logic        cp;
	logic        irq;
	cfl_flags_t  flags;
	logic [31:0] d;
	logic        e;
	int          n_fail = 0;
	int          checked = 0;
	int          nwr = 0;
	int          nrd = 0;
	int          np = 0;

	always #25 pclk = ~pclk;
	// strobe counters seen at each edge
	always @(posedge pclk) begin
		nwr += int'(|wr_en);
		nrd += int'(|rd_en);
		np  += int'(cp);
	end

	cfl_top u_cfl_top (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
		.pwdata, .prdata, .pready, .pslverr, .next_bin_pulse(nb), .rd_req,
		.chip_flags_pin(5'h00), .chip_wr_en(wr_en), .chip_rd_en(rd_en),
		.copy_chan(chan), .copy_pulse_out(cp), .fifo_flags(flags), .irq);
	cfl_reader u_cfl_reader (.pclk, .presetn, .en, .slow,
		.fifo_flags(flags), .rd_req);

	////////////////////////////////////////
	// one apb transfer, a spare edge after it
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] v);
		int k;
		k = 0;
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= v;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		d = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// one next bin pulse
	task automatic bin();
		nb <= 1'b1;
		@(posedge pclk);
		nb <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic end_sim();
		if (n_fail == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		#100000;
		n_fail++;
		end_sim();
	end

	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, REG_FLAGS, 0);    `CHK("flags", 32'h1, d)
		apb(0, REG_WORDS, 0);    `CHK("words", 32'h20, d)
		apb(0, REG_IRQ_MASK, 0); `CHK("mask", 32'h0, d)
		apb(0, 8'h18, 0);        `CHK("unmapped", 1'b1, e)
		apb(1, REG_WORDS, 5);
		bin();
		repeat (40) @(posedge pclk);
		`CHK("writes", 5, nwr)
		`CHK("chan", 6'h4, chan)
		apb(0, REG_FILL, 0);     `CHK("fill", 32'h5, d)
		apb(0, REG_FLAGS, 0);    `CHK("flags", 32'h0, d)
		// bin lost while one waits, interrupt masked
		apb(1, REG_WORDS, 20);
		bin();
		repeat (3) @(posedge pclk);
		bin();
		bin();
		repeat (100) @(posedge pclk);
		`CHK("writes", 45, nwr)
		`CHK("chan", 6'h13, chan)
		`CHK("irq", 1'b0, irq)
		apb(0, REG_IRQ_STAT, 0); `CHK("stat", 32'h4, d)
		apb(1, REG_IRQ_MASK, 4);
		@(posedge pclk);
		`CHK("irq", 1'b1, irq)
		apb(1, REG_IRQ_STAT, 4);
		@(posedge pclk);
		`CHK("irq", 1'b0, irq)
		// copy disable: pulse but no words
		apb(1, REG_CTRL, 1);
		bin();
		repeat (40) @(posedge pclk);
		`CHK("pulses", 4, np)
		`CHK("writes", 45, nwr)
		apb(1, REG_CTRL, 0);
		// drain slowly, then read beside a live bin
		en <= 1'b1;
		repeat (120) @(posedge pclk);
		`CHK("reads", 45, nrd)
		apb(0, REG_FLAGS, 0);    `CHK("flags", 32'h1, d)
		slow <= 1'b0;
		bin();
		repeat (60) @(posedge pclk);
		`CHK("reads", 65, nrd)
		apb(0, REG_FILL, 0);     `CHK("fill", 32'h0, d)
		end_sim();
	end
endmodule
`default_nettype wire
